// [shared/adc_io_pkg.sv]
package adc_io_pkg;
  localparam logic [0:5] OPCODE_IO_XFER = 6'h38;
  localparam logic [0:5] DEVICE_CODE    = 6'h0B;
  localparam logic [0:1] SUB_CONVERT    = 2'h0;
  localparam logic [0:1] SUB_READ_DATA  = 2'h0;
  localparam logic [0:1] SUB_READ_STATE = 2'h2;
  localparam logic [0:1] SUB_CLEAR      = 2'h3;
  localparam logic [0:1] SUB_SKIP_DONE  = 2'h0;
  localparam logic [0:1] SUB_SKIP_COUNT = 2'h2;
  localparam logic [0:1] SUB_SKIP_SIGN  = 2'h1;
  localparam int INSTR_OP_LO    = 0;
  localparam int INSTR_DEV_LO   = 6;
  localparam int INSTR_SUB_LO   = 12;
  localparam int INSTR_WRITE    = 15;
  localparam int INSTR_READ     = 16;
  localparam int INSTR_TEST     = 17;
  localparam int WORD_W         = 18;
  localparam int GAIN_LO        = 0;
  localparam int CTRL_LO        = 6;
  localparam int CTRL_W         = 5;
  localparam int CHAN_LO        = 11;
  localparam int CHAN_W         = 7;
  localparam int MUX_INPUT_W    = 5;
  localparam int CTRL_EXT_SYNC  = 4;
  localparam int REPORT_WCO_BIT = 4;
  localparam int REPORT_MSO_BIT = 5;
  localparam int RESULT_W       = 12;
  localparam int SIGN_FILL_W    = 6;
  localparam logic [0:17] SETUP_RESET = 18'h00000;
  localparam logic [0:17] WORD_ZERO   = 18'h00000;
  localparam int SETTLE_TIME_NS = 4500;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    SEQ_IDLE   = 4'h1,
    SEQ_SETTLE = 4'h2,
    SEQ_SYNC   = 4'h4,
    SEQ_CONV   = 4'h8
  } seq_state_e;
endpackage

// [shared/adc_ctl_if.sv]
`timescale 1ns/1ns
interface adc_ctl_if;
  logic cmdStart;
  logic cmdReadResult;
  logic cmdReadState;
  logic cmdClear;
  logic testDone;
  logic testCount;
  logic testSign;
  logic extSync;
  logic convertFire;
  logic doneEvent;
  logic busy;
  modport decoder (output cmdStart, cmdReadResult, cmdReadState, cmdClear,
                   output testDone, testCount, testSign);
  modport sequencer (input cmdStart, extSync, output convertFire, doneEvent, busy);
  modport core (input cmdStart, cmdReadResult, cmdReadState, cmdClear,
                input testDone, testCount, testSign, convertFire, doneEvent, busy,
                output extSync);
endinterface

// [rtl/iot_command_decoder.sv]
`timescale 1ns/1ns
module iot_command_decoder (
  input  wire logic [0:17]    ioInstr,
  input  wire logic           pulseWriteIn,
  input  wire logic           pulseReadOut,
  input  wire logic           pulseFlagTest,
  adc_ctl_if.decoder          ctl
);
  // bit 14 is the processor's own accumulator clear and is left undecoded
  logic       devMatch;
  logic [0:1] sub;
  logic       writeHit;
  logic       readHit;
  logic       testHit;

  function automatic logic subIs(input logic [0:1] s, input logic [0:1] code);
    return s == code;
  endfunction

  assign devMatch = (ioInstr[adc_io_pkg::INSTR_OP_LO +: 6] == adc_io_pkg::OPCODE_IO_XFER) &&
                    (ioInstr[adc_io_pkg::INSTR_DEV_LO +: 6] == adc_io_pkg::DEVICE_CODE);
  assign sub      = ioInstr[adc_io_pkg::INSTR_SUB_LO +: 2];
  assign writeHit = devMatch && pulseWriteIn && ioInstr[adc_io_pkg::INSTR_WRITE];
  assign readHit  = devMatch && pulseReadOut && ioInstr[adc_io_pkg::INSTR_READ];
  assign testHit  = devMatch && pulseFlagTest && ioInstr[adc_io_pkg::INSTR_TEST];

  assign ctl.cmdStart      = writeHit && subIs(sub, adc_io_pkg::SUB_CONVERT);
  assign ctl.cmdReadResult = readHit && subIs(sub, adc_io_pkg::SUB_READ_DATA);
  assign ctl.cmdReadState  = readHit && subIs(sub, adc_io_pkg::SUB_READ_STATE);
  assign ctl.cmdClear      = readHit && subIs(sub, adc_io_pkg::SUB_CLEAR);
  assign ctl.testDone      = testHit && subIs(sub, adc_io_pkg::SUB_SKIP_DONE);
  assign ctl.testCount     = testHit && subIs(sub, adc_io_pkg::SUB_SKIP_COUNT);
  assign ctl.testSign      = testHit && subIs(sub, adc_io_pkg::SUB_SKIP_SIGN);
endmodule

// [rtl/conversion_sequencer.sv]
`timescale 1ns/1ns
module conversion_sequencer #(
  parameter int SETTLE_CYCLES = adc_io_pkg::SETTLE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic extSyncPulse,
  input  wire logic converterDone,
  adc_ctl_if.sequencer ctl
);
  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CYCLES - 1);

  adc_io_pkg::seq_state_e state_r;
  adc_io_pkg::seq_state_e state_nxt;
  logic [CNT_W-1:0]       settleCnt_r;
  logic                   settleEnd;

  assign settleEnd       = (state_r == adc_io_pkg::SEQ_SETTLE) && (settleCnt_r == CNT_LAST);
  assign ctl.convertFire = settleEnd || ((state_r == adc_io_pkg::SEQ_SYNC) && extSyncPulse);
  assign ctl.doneEvent   = (state_r == adc_io_pkg::SEQ_CONV) && converterDone && !ctl.cmdStart;
  assign ctl.busy        = state_r != adc_io_pkg::SEQ_IDLE;

  // a new convert restarts the timing from scratch, even mid-conversion
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      adc_io_pkg::SEQ_IDLE:   state_nxt = state_r;
      adc_io_pkg::SEQ_SETTLE: if (settleEnd) state_nxt = adc_io_pkg::SEQ_CONV;
      adc_io_pkg::SEQ_SYNC:   if (extSyncPulse) state_nxt = adc_io_pkg::SEQ_CONV;
      adc_io_pkg::SEQ_CONV:   if (converterDone) state_nxt = adc_io_pkg::SEQ_IDLE;
      default:                state_nxt = adc_io_pkg::SEQ_IDLE;
    endcase
    if (ctl.cmdStart) begin
      state_nxt = ctl.extSync ? adc_io_pkg::SEQ_SYNC : adc_io_pkg::SEQ_SETTLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r     <= adc_io_pkg::SEQ_IDLE;
      settleCnt_r <= '0;
    end else begin
      state_r     <= state_nxt;
      settleCnt_r <= (state_nxt == adc_io_pkg::SEQ_SETTLE && !ctl.cmdStart) ?
                     settleCnt_r + CNT_W'(1) : '0;
    end
  end

  a_settle_length: assert property (@(posedge core_clk) disable iff (reset)
    settleEnd |-> $past(state_r, 1) == adc_io_pkg::SEQ_SETTLE &&
                  settleCnt_r == CNT_LAST)
    else $error("settling ended at the wrong count");
  a_int_sync_path: assert property (@(posedge core_clk) disable iff (reset)
    ctl.cmdStart && !ctl.extSync |=> state_r == adc_io_pkg::SEQ_SETTLE && settleCnt_r == '0)
    else $error("internal sync start did not enter settling");
endmodule

// [rtl/adc_host_io_command_port.sv]
`timescale 1ns/1ns
module adc_host_io_command_port #(
  parameter int SETTLE_CYCLES = adc_io_pkg::SETTLE_CYCLES
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [0:17]  ioInstr,
  input  wire logic         pulseWriteIn,
  input  wire logic         pulseReadOut,
  input  wire logic         pulseFlagTest,
  input  wire logic [0:17]  busDataIn,
  output logic      [0:17]  busDataOut,
  output logic              busDataOeN,
  output logic              skipRequest,
  input  wire logic         wordCountOverflow,
  input  wire logic         channelBreakEvent,
  input  wire logic         addMemStrobe,
  input  wire logic [0:17]  addMemOld,
  input  wire logic [0:17]  addMemSum,
  input  wire logic         extSyncPulse,
  input  wire logic         converterDone,
  input  wire logic [0:11]  converterResult,
  output logic              converterStart,
  output logic              gainSelectHigh,
  output logic              gainSelectLow,
  output logic      [3:0]   gainFactor,
  output logic              muxSelectHigh,
  output logic              muxSelectLow,
  output logic      [0:4]   muxInput,
  output logic      [0:4]   controlBits,
  output logic              doneFlag,
  output logic              countOverflowFlag,
  output logic              sumSignFlag,
  output logic              channelBreakRequestFlag
);
  adc_ctl_if ctl ();

  logic [0:17] setup_r;
  logic [0:11] result_r;
  logic [0:17] busData_r;
  logic        busOeN_r;
  logic        done_r;
  logic        wco_r;
  logic        mso_r;
  logic        chanBreak_r;
  logic        start_r;

  logic [0:17] resultWord;
  logic [0:17] reportWord;
  logic [0:6]  chanAddr;
  logic [0:1]  gainCode;
  logic        signChange;
  logic        doneClear;
  logic        skipDone;
  logic        skipCount;
  logic        skipSign;

  function automatic logic [3:0] gainOf(input logic [0:1] code);
    logic [3:0] g;
    g = 4'h0;
    case (code)
      2'h0:    g = 4'h1;
      2'h1:    g = 4'h2;
      2'h2:    g = 4'h4;
      2'h3:    g = 4'h8;
      default: g = 4'h1;
    endcase
    return g;
  endfunction

  function automatic logic [0:17] signFill(input logic [0:11] r);
    return {{adc_io_pkg::SIGN_FILL_W{r[0]}}, r};
  endfunction

  iot_command_decoder u_decoder (
    .ioInstr       (ioInstr),
    .pulseWriteIn  (pulseWriteIn),
    .pulseReadOut  (pulseReadOut),
    .pulseFlagTest (pulseFlagTest),
    .ctl           (ctl.decoder)
  );

  conversion_sequencer #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_sequencer (
    .core_clk      (core_clk),
    .reset         (reset),
    .extSyncPulse  (extSyncPulse),
    .converterDone (converterDone),
    .ctl           (ctl.sequencer)
  );

  // setup word fields; bits 2-5 of the setup word go nowhere
  assign gainCode       = setup_r[adc_io_pkg::GAIN_LO +: 2];
  assign chanAddr       = setup_r[adc_io_pkg::CHAN_LO +: adc_io_pkg::CHAN_W];
  assign gainSelectHigh = gainCode[0];
  assign gainSelectLow  = gainCode[1];
  assign gainFactor     = gainOf(gainCode);
  assign muxSelectHigh  = chanAddr[0];
  assign muxSelectLow   = chanAddr[1];
  assign muxInput       = chanAddr[2 +: adc_io_pkg::MUX_INPUT_W];
  assign controlBits    = setup_r[adc_io_pkg::CTRL_LO +: adc_io_pkg::CTRL_W];
  assign ctl.extSync    = busDataIn[adc_io_pkg::CTRL_LO + adc_io_pkg::CTRL_EXT_SYNC];

  // the sync choice is read straight off the bus, since the setup register only
  // updates on the same edge the sequencer commits its path
  assign converterStart = ctl.convertFire;

  assign resultWord = signFill(result_r);
  always_comb begin
    reportWord = adc_io_pkg::WORD_ZERO;
    reportWord[adc_io_pkg::REPORT_WCO_BIT] = wco_r;
    reportWord[adc_io_pkg::REPORT_MSO_BIT] = mso_r;
    reportWord[adc_io_pkg::CHAN_LO +: adc_io_pkg::CHAN_W] = chanAddr;
  end

  assign signChange = addMemStrobe && (addMemOld[0] != addMemSum[0]);
  assign doneClear  = ctl.cmdStart || ctl.cmdReadResult || ctl.cmdClear;

  assign skipDone    = ctl.testDone && done_r;
  assign skipCount   = ctl.testCount && wco_r;
  assign skipSign    = ctl.testSign && mso_r;
  assign skipRequest = skipDone || skipCount || skipSign;

  assign busDataOut              = busData_r;
  assign busDataOeN              = busOeN_r;
  assign doneFlag                = done_r;
  assign countOverflowFlag       = wco_r;
  assign sumSignFlag             = mso_r;
  assign channelBreakRequestFlag = chanBreak_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      setup_r <= adc_io_pkg::SETUP_RESET;
    end else if (ctl.cmdStart) begin
      setup_r <= busDataIn;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      result_r <= '0;
    end else if (ctl.doneEvent) begin
      result_r <= converterResult;
    end
  end

  // hardware set wins over a clear in the same cycle, except a convert command, which blocks the done set
  always_ff @(posedge core_clk) begin
    if (reset) begin
      done_r <= 1'b0;
      wco_r  <= 1'b0;
      mso_r  <= 1'b0;
      chanBreak_r <= 1'b0;
    end else begin
      done_r <= ctl.doneEvent || (done_r && !doneClear);
      wco_r  <= wordCountOverflow || (wco_r && !ctl.cmdClear);
      mso_r  <= signChange || (mso_r && !ctl.cmdClear);
      chanBreak_r <= channelBreakEvent || (chanBreak_r && !ctl.cmdClear);
    end
  end

  // one word on the bus for the cycle after the read pulse
  always_ff @(posedge core_clk) begin
    if (reset) begin
      busData_r <= adc_io_pkg::WORD_ZERO;
      busOeN_r  <= 1'b1;
    end else begin
      busOeN_r  <= !(ctl.cmdReadResult || ctl.cmdReadState);
      busData_r <= ctl.cmdReadResult ? resultWord :
                   ctl.cmdReadState  ? reportWord :
                   adc_io_pkg::WORD_ZERO;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      start_r <= 1'b0;
    end else begin
      start_r <= ctl.cmdStart;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_wrong_device: assert property (
    ioInstr[adc_io_pkg::INSTR_DEV_LO +: 6] != adc_io_pkg::DEVICE_CODE |->
      !ctl.cmdStart && !ctl.cmdReadResult && !ctl.cmdReadState && !skipRequest)
    else $error("command taken for another device code");
  a_subdevice_split: assert property (
    !(ctl.cmdReadResult && ctl.cmdReadState) && !(ctl.cmdReadState && ctl.cmdClear))
    else $error("two read-side commands decoded together");
  a_convert_load: assert property (
    ctl.cmdStart |=> setup_r == $past(busDataIn) && (done_r == $past(ctl.doneEvent)))
    else $error("convert did not load setup or clear done");
  a_read_result: assert property (
    ctl.cmdReadResult |=> !busDataOeN && busDataOut == signFill($past(result_r)) ##1
      (busDataOeN || $past(ctl.cmdReadResult || ctl.cmdReadState)))
    else $error("result word not driven for exactly one cycle");
  a_report_layout: assert property (
    ctl.cmdReadState |=> !busDataOeN &&
      busDataOut[adc_io_pkg::REPORT_WCO_BIT] == $past(wco_r) &&
      busDataOut[adc_io_pkg::REPORT_MSO_BIT] == $past(mso_r) &&
      busDataOut[0:3] == 4'h0 && busDataOut[6:10] == 5'h00 &&
      busDataOut[adc_io_pkg::CHAN_LO +: adc_io_pkg::CHAN_W] == $past(chanAddr))
    else $error("state report word malformed");
  a_clear_all: assert property (
    ctl.cmdClear && !ctl.doneEvent && !wordCountOverflow && !signChange && !channelBreakEvent
      |=> !done_r && !wco_r && !mso_r && !chanBreak_r)
    else $error("clear flags left a flag standing");
  a_skip_select: assert property (
    skipRequest |-> (ctl.testDone && done_r) || (ctl.testCount && wco_r) ||
                    (ctl.testSign && mso_r))
    else $error("skip without matching flag");
  a_skip_done: assert property (
    ctl.testDone && done_r |-> skipRequest)
    else $error("done test failed to skip");
  a_sum_sign: assert property (
    addMemStrobe && addMemOld[0] != addMemSum[0] |=> mso_r [*2] or
      ($past(ctl.cmdClear) == 1'b0 && mso_r))
    else $error("sign change on add-to-memory not flagged");
  a_done_sets: assert property (
    ctl.doneEvent |=> done_r && result_r == $past(converterResult))
    else $error("completion did not set done");
  a_gain_map: assert property (
    gainFactor == (4'h1 << gainCode))
    else $error("gain code mapped wrongly");
  a_setup_ignored: assert property (
    $changed(setup_r[2:5]) && $stable(setup_r[0:1]) && $stable(setup_r[6:17]) |->
      $stable(gainFactor) && $stable(muxInput) && $stable(controlBits))
    else $error("unused setup bits changed conversion setup");
  a_convert_follows: assert property (
    start_r && !ctl.busy |-> 1'b0)
    else $error("convert did not start the timing sequence");

  c_convert_done: cover property (ctl.cmdStart ##[1:1000] ctl.doneEvent);
  c_skip_done:    cover property (skipDone);
  c_read_result:  cover property (ctl.cmdReadResult && done_r);
  c_sign_flag:    cover property (signChange ##1 ctl.testSign);
endmodule

// [tb/io_proc_model.sv]
`timescale 1ns/1ns
module io_proc_model (
  input  wire logic        core_clk,
  output logic      [0:17] ioInstr,
  output logic             pulseWriteIn,
  output logic             pulseReadOut,
  output logic             pulseFlagTest,
  output logic      [0:17] busDataIn,
  input  wire logic [0:17] busDataOut,
  input  wire logic        busDataOeN,
  input  wire logic        skipRequest
);
  initial begin
    ioInstr = 18'h00000;
    busDataIn = 18'h00000;
    {pulseWriteIn, pulseReadOut, pulseFlagTest} = 3'h0;
  end

  // pulses go out in the order test, read, write; lines left idle show inverted values
  task automatic ioXfer(input logic [0:17] ins, input logic [0:17] ac,
                     output logic sk, output logic [0:17] acOut);
    sk = 1'b0;
    acOut = ins[14] ? 18'h00000 : ac;
    for (int b = 17; b >= 15; b--) begin
      if (ins[b]) begin
        @(posedge core_clk);
        ioInstr <= ins;
        busDataIn <= ac;
        pulseFlagTest <= (b == 17);
        pulseReadOut <= (b == 16);
        pulseWriteIn <= (b == 15);
        @(negedge core_clk);
        if (b == 17) sk = skipRequest;
        @(posedge core_clk);
        {pulseWriteIn, pulseReadOut, pulseFlagTest} <= 3'h0;
        ioInstr <= ~ins;
        busDataIn <= ~ac;
        @(negedge core_clk);
        if (busDataOeN === 1'b0) acOut = acOut | busDataOut;
      end
    end
  endtask
endmodule

// [tb/tb_adc_host_io_command_port.sv]
`timescale 1ns/1ns
module tb_adc_host_io_command_port;
  localparam int ST = 4;
  localparam logic [0:17] CONV = 18'h382C4;
  localparam logic [0:17] RDB  = 18'h382CA;
  localparam logic [0:17] RDS  = 18'h382E2;
  localparam logic [0:17] CLR  = 18'h382F2;
  localparam logic [0:17] SKDN = 18'h382C1;
  localparam logic [0:17] SKWC = 18'h382E1;
  localparam logic [0:17] SKMS = 18'h382D1;
  logic        core_clk = 1'b0;
  logic        reset;
  logic [0:17] ioInstr, busDataIn, busDataOut, addMemOld, addMemSum, setup, acv;
  logic        pulseWriteIn, pulseReadOut, pulseFlagTest, busDataOeN, skipRequest;
  logic        wordCountOverflow, channelBreakEvent, addMemStrobe, extSyncPulse;
  logic        converterDone, converterStart, sk, st, seen;
  logic [0:11] converterResult, res;
  logic        gainSelectHigh, gainSelectLow, muxSelectHigh, muxSelectLow;
  logic [3:0]  gainFactor;
  logic [0:4]  muxInput, controlBits;
  logic        doneFlag, countOverflowFlag, sumSignFlag, channelBreakRequestFlag;
  logic [0:17] bad [3] = '{18'h392C4, 18'h38304, 18'h382E4};
  logic [31:0] seed = 32'h749A;
  int          nErrors = 0;
  int          numChecks = 0;
  int          n;

  always #2 core_clk = ~core_clk;

  io_proc_model i_io_proc_model (.core_clk(core_clk), .ioInstr(ioInstr),
    .pulseWriteIn(pulseWriteIn), .pulseReadOut(pulseReadOut), .pulseFlagTest(pulseFlagTest),
    .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOeN(busDataOeN),
    .skipRequest(skipRequest));

  adc_host_io_command_port #(.SETTLE_CYCLES(ST)) i_adc_host_io_command_port (
    .core_clk(core_clk), .reset(reset), .ioInstr(ioInstr), .pulseWriteIn(pulseWriteIn),
    .pulseReadOut(pulseReadOut), .pulseFlagTest(pulseFlagTest), .busDataIn(busDataIn),
    .busDataOut(busDataOut), .busDataOeN(busDataOeN), .skipRequest(skipRequest),
    .wordCountOverflow(wordCountOverflow), .channelBreakEvent(channelBreakEvent),
    .addMemStrobe(addMemStrobe), .addMemOld(addMemOld), .addMemSum(addMemSum),
    .extSyncPulse(extSyncPulse), .converterDone(converterDone),
    .converterResult(converterResult), .converterStart(converterStart),
    .gainSelectHigh(gainSelectHigh), .gainSelectLow(gainSelectLow), .gainFactor(gainFactor),
    .muxSelectHigh(muxSelectHigh), .muxSelectLow(muxSelectLow), .muxInput(muxInput),
    .controlBits(controlBits), .doneFlag(doneFlag), .countOverflowFlag(countOverflowFlag),
    .sumSignFlag(sumSignFlag), .channelBreakRequestFlag(channelBreakRequestFlag));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [3:0] gainExp(input logic [0:1] g);
    return 4'h1 << g;
  endfunction

  task automatic chk(input logic [0:17] a, input logic [0:17] e);
    numChecks++;
    if (a !== e) begin
      nErrors++;
      $display("ERROR t=%0t act=%h exp=%h", $time, a, e);
    end
  endtask

  task automatic chkb(input logic a, input logic e);
    numChecks++;
    if (a !== e) begin
      nErrors++;
      $display("ERROR t=%0t act=%h exp=%h", $time, a, e);
    end
  endtask

  // event mask order: count overflow, channel break, add-to-memory, ext sync, converter done
  task automatic fire(input logic [4:0] m, input logic [0:17] a, input logic [0:17] b,
                      output logic s);
    @(posedge core_clk);
    {wordCountOverflow, channelBreakEvent, addMemStrobe, extSyncPulse, converterDone} <= m;
    addMemOld <= a;
    addMemSum <= b;
    converterResult <= a[6:17];
    @(negedge core_clk);
    s = converterStart;
    @(posedge core_clk);
    {wordCountOverflow, channelBreakEvent, addMemStrobe, extSyncPulse, converterDone} <= 5'h00;
    addMemOld <= ~a;
    addMemSum <= ~b;
    converterResult <= ~a[6:17];
    @(negedge core_clk);
  endtask

  task automatic results();
    if (nErrors == 0 && numChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #40000;
    nErrors++;
    results();
  end

  initial begin
    {wordCountOverflow, channelBreakEvent, addMemStrobe, extSyncPulse, converterDone} = 5'h00;
    addMemOld = 18'h00000;
    addMemSum = 18'h00000;
    converterResult = 12'h000;
    reset = 1'b1;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chk(18'(gainFactor), 18'h00001);
    // odd passes leave done set so the next convert has to clear it
    for (int i = 0; i < 6; i++) begin
      setup = (i == 0) ? 18'h3FF7F : (i == 1) ? 18'h00000 : 18'(xs()) & 18'h3FF7F;
      res = (i == 0) ? 12'h800 : (i == 2) ? 12'h7FF : 12'(xs());
      i_io_proc_model.ioXfer(CONV, setup, sk, acv);
      chkb(doneFlag, 1'b0);
      chk(18'(gainFactor), 18'(gainExp(setup[0:1])));
      chk(18'({gainSelectHigh, gainSelectLow, controlBits}), 18'({setup[0:1], setup[6:10]}));
      chk(18'({muxSelectHigh, muxSelectLow, muxInput}), 18'(setup[11:17]));
      n = 1;
      while (converterStart !== 1'b1 && n < 40) begin
        @(negedge core_clk);
        n++;
      end
      chk(18'(n), 18'(ST));
      fire(5'h01, {6'h00, res}, 18'h00000, st);
      chkb(doneFlag, 1'b1);
      i_io_proc_model.ioXfer(SKDN, 18'(xs()), sk, acv);
      chkb(sk, 1'b1);
      if (i % 2 == 0) begin
        i_io_proc_model.ioXfer(RDB, 18'(xs()), sk, acv);
        chk(acv, {{6{res[0]}}, res});
        chkb(doneFlag, 1'b0);
        i_io_proc_model.ioXfer(SKDN, 18'(xs()), sk, acv);
        chkb(sk, 1'b0);
      end
    end
    setup = 18'(xs()) | 18'h00080;
    i_io_proc_model.ioXfer(CONV, setup, sk, acv);
    seen = 1'b0;
    repeat (8) begin
      @(negedge core_clk);
      seen = seen | converterStart;
    end
    chkb(seen, 1'b0);
    fire(5'h02, 18'h00000, 18'h00000, st);
    chkb(st, 1'b1);
    fire(5'h01, 18'(xs()), 18'h00000, st);
    fire(5'h10, 18'h00000, 18'h00000, st);
    i_io_proc_model.ioXfer(SKWC, 18'h00000, sk, acv);
    chkb(sk, 1'b1);
    fire(5'h04, 18'h00001, 18'h00002, st);
    chkb(sumSignFlag, 1'b0);
    i_io_proc_model.ioXfer(SKMS, 18'h00000, sk, acv);
    chkb(sk, 1'b0);
    fire(5'h04, 18'h1FFFF, 18'h20000, st);
    chkb(sumSignFlag, 1'b1);
    i_io_proc_model.ioXfer(SKMS, 18'h00000, sk, acv);
    chkb(sk, 1'b1);
    fire(5'h08, 18'h00000, 18'h00000, st);
    chkb(channelBreakRequestFlag, 1'b1);
    i_io_proc_model.ioXfer(RDS, 18'h00000, sk, acv);
    chk(acv, {4'h0, 2'h3, 5'h00, setup[11:17]});
    i_io_proc_model.ioXfer(CLR, 18'h00000, sk, acv);
    chk(18'({doneFlag, countOverflowFlag, sumSignFlag, channelBreakRequestFlag}), 18'h0);
    i_io_proc_model.ioXfer(SKWC, 18'h00000, sk, acv);
    chkb(sk, 1'b0);
    // near-miss codes: wrong opcode, wrong device, wrong subdevice
    for (int k = 0; k < 3; k++) begin
      i_io_proc_model.ioXfer(bad[k], ~setup, sk, acv);
      chk(18'({gainSelectHigh, gainSelectLow, controlBits, muxSelectHigh, muxSelectLow,
               muxInput}), 18'({setup[0:1], setup[6:17]}));
    end
    results();
  end
endmodule
